/* File: rtl/alu_pkg.sv */
// Shared constants, types and helper functions for the add/and datapath.
package alu_pkg;

	// Register byte offsets on the control bus.
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_ACCUM  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FADDR  = 8'h0C;
	localparam logic [7:0] OFS_FDATA  = 8'h10;

	// Status register field positions.
	localparam int unsigned STAT_C_BIT     = 0;
	localparam int unsigned STAT_DC_BIT    = 1;
	localparam int unsigned STAT_Z_BIT     = 2;
	localparam int unsigned STAT_BUSY_BIT  = 8;
	localparam int unsigned STAT_UNSUP_BIT = 9;

	// Values after reset.
	localparam logic [7:0]  ACCUM_RST = 8'h00;
	localparam logic [13:0] INSTR_RST = 14'h0000;
	localparam logic [6:0]  FADDR_RST = 7'h00;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Opcode fields, instruction bits 13:8, and the destination bit position.
	localparam logic [5:0] OPC_ADDL      = 6'h3E;
	localparam logic [5:0] OPC_ADDL_MASK = 6'h3E;
	localparam logic [5:0] OPC_ANDL      = 6'h39;
	localparam logic [5:0] OPC_ADDF      = 6'h07;
	localparam logic [5:0] OPC_ANDF      = 6'h05;
	localparam int unsigned DEST_BIT     = 7;

	// One instruction cycle is this many clock periods, one per phase.
	localparam int unsigned PHASES_PER_CYCLE = 4;
	localparam int unsigned FILE_DEPTH       = 128;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_Q1   = 3'b001,
		PH_Q2   = 3'b011,
		PH_Q3   = 3'b010,
		PH_Q4   = 3'b110
	} phase_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADDL,
		OP_ANDL,
		OP_ADDF,
		OP_ANDF
	} op_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} flags_t;

	localparam flags_t FLAGS_RST = 3'b000;

	typedef struct packed {
		logic [7:0] res;
		flags_t     flags;
	} alu_out_t;

	function automatic op_t decode_op(input logic [13:0] instr);
		logic [5:0] opc;
		opc = instr[13:8];
		if ((opc & OPC_ADDL_MASK) == OPC_ADDL) return OP_ADDL;
		if (opc == OPC_ANDL) return OP_ANDL;
		if (opc == OPC_ADDF) return OP_ADDF;
		if (opc == OPC_ANDF) return OP_ANDF;
		return OP_NONE;
	endfunction : decode_op

	function automatic logic is_file_op(input op_t op);
		return (op == OP_ADDF) || (op == OP_ANDF);
	endfunction : is_file_op

	function automatic alu_out_t alu_calc(input op_t op, input logic [7:0] a,
			input logic [7:0] b, input flags_t fin);
		alu_out_t   o;
		logic [8:0] sum;
		logic [4:0] nib;
		o   = '{res: 8'h00, flags: fin};
		sum = {1'b0, a} + {1'b0, b};
		nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		if (op == OP_ADDL || op == OP_ADDF) begin
			o.res      = sum[7:0];
			o.flags.c  = sum[8];
			o.flags.dc = nib[4];
		end else begin
			o.res = a & b;
		end
		o.flags.z = (o.res == 8'h00);
		return o;
	endfunction : alu_calc

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge_strb

endpackage : alu_pkg

/* File: rtl/file_ram.sv */
// Byte-wide file register memory with one write port and a registered read port.
`timescale 1ns/10ps
module file_ram #(
	parameter int unsigned DEPTH = 128,
	parameter int unsigned WIDTH = 8,
	localparam int unsigned AW   = $clog2(DEPTH)
) (
	input  wire logic             clk,   // Core clock.
	input  wire logic             we,    // Write enable.
	input  wire logic [AW-1:0]    waddr, // Write address.
	input  wire logic [WIDTH-1:0] wdata, // Write data.
	input  wire logic             re,    // Read enable.
	input  wire logic [AW-1:0]    raddr, // Read address.
	output logic      [WIDTH-1:0] rdata  // Read data, valid the cycle after re.
);
	if (DEPTH < 2 || WIDTH < 1 || (1 << AW) != DEPTH) begin : g_bad_size
		$error("file_ram needs a power-of-two depth of at least two");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// Read-first: a same-cycle write shows up only on the next read.
	always_ff @(posedge clk) begin
		if (we) mem[waddr] <= wdata;
		if (re) rdata <= mem[raddr];
	end
endmodule : file_ram

/* File: rtl/add_and_literal_file_alu.sv */
// Four-phase datapath for add/and on the accumulator with literal or file operand.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module add_and_literal_file_alu
	import alu_pkg::*;
(
	input  wire logic        aclk,       // Core clock, 20 MHz.
	input  wire logic        aresetn,    // Synchronous reset, active low.
	input  wire logic [7:0]  s_awaddr,   // Write address.
	input  wire logic [2:0]  s_awprot,   // Write protection, unused.
	input  wire logic        s_awvalid,  // Write address valid.
	output logic             s_awready,  // Write address ready.
	input  wire logic [31:0] s_wdata,    // Write data.
	input  wire logic [3:0]  s_wstrb,    // Write byte strobes.
	input  wire logic        s_wvalid,   // Write data valid.
	output logic             s_wready,   // Write data ready.
	output logic [1:0]       s_bresp,    // Write response.
	output logic             s_bvalid,   // Write response valid.
	input  wire logic        s_bready,   // Write response ready.
	input  wire logic [7:0]  s_araddr,   // Read address.
	input  wire logic [2:0]  s_arprot,   // Read protection, unused.
	input  wire logic        s_arvalid,  // Read address valid.
	output logic             s_arready,  // Read address ready.
	output logic [31:0]      s_rdata,    // Read data.
	output logic [1:0]       s_rresp,    // Read response.
	output logic             s_rvalid,   // Read data valid.
	input  wire logic        s_rready,   // Read data ready.
	output logic             exec_busy,  // High while an instruction cycle runs.
	output flags_t           flags       // Carry, digit carry and zero flags.
);
	localparam int unsigned FAW = $clog2(FILE_DEPTH);

	// Execution state.
	phase_t      phase_q, phase_d;
	op_t         op_q, op_d;
	logic [13:0] instr_q, instr_d;
	logic [7:0]  accum_q, accum_d;
	logic [7:0]  oper_q, oper_d;
	alu_out_t    alu_q, alu_d;
	flags_t      flags_q, flags_d;
	logic        unsup_q, unsup_d;
	logic [6:0]  faddr_q, faddr_d;

	// Bus state.
	logic        aw_have_q, aw_have_d;
	logic        w_have_q, w_have_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic        rd_pend_q, rd_pend_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	// Memory port.
	logic           mem_we, mem_re;
	logic [FAW-1:0] mem_waddr, mem_raddr;
	logic [7:0]     mem_wdata, mem_rdata;

	logic        wr_go, rd_go;
	logic [31:0] status_word, wr_word;

	file_ram #(
		.DEPTH (FILE_DEPTH),
		.WIDTH (8)
	) u_file_ram (
		.clk   (aclk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.re    (mem_re),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// Register writes and instruction starts wait for the idle phase, so the
	// file memory never sees a bus access and a core access in one cycle.
	assign s_awready = !aw_have_q && !bvalid_q;
	assign s_wready  = !w_have_q && !bvalid_q;
	assign s_arready = !rvalid_q && !rd_pend_q && (phase_q == PH_IDLE);
	assign wr_go     = aw_have_q && w_have_q && !bvalid_q && (phase_q == PH_IDLE);
	assign rd_go     = s_arvalid && s_arready;

	always_comb begin
		status_word                 = 32'h0000_0000;
		status_word[STAT_C_BIT]     = flags_q.c;
		status_word[STAT_DC_BIT]    = flags_q.dc;
		status_word[STAT_Z_BIT]     = flags_q.z;
		status_word[STAT_BUSY_BIT]  = (phase_q != PH_IDLE);
		status_word[STAT_UNSUP_BIT] = unsup_q;
	end

	always_comb begin
		phase_d   = phase_q;
		op_d      = op_q;
		instr_d   = instr_q;
		accum_d   = accum_q;
		oper_d    = oper_q;
		alu_d     = alu_q;
		flags_d   = flags_q;
		unsup_d   = unsup_q;
		faddr_d   = faddr_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rd_pend_d = 1'b0;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		mem_we    = 1'b0;
		mem_waddr = faddr_q;
		mem_wdata = 8'h00;
		mem_re    = 1'b0;
		mem_raddr = faddr_q;
		wr_word   = 32'h0000_0000;

		unique case (phase_q)
			PH_IDLE: begin
			end
			PH_Q1: begin
				op_d      = decode_op(instr_q);
				mem_re    = 1'b1;
				mem_raddr = instr_q[6:0];
				phase_d   = PH_Q2;
			end
			PH_Q2: begin
				oper_d  = is_file_op(op_q) ? mem_rdata : instr_q[7:0];
				phase_d = PH_Q3;
			end
			PH_Q3: begin
				alu_d   = alu_calc(op_q, accum_q, oper_q, flags_q);
				phase_d = PH_Q4;
			end
			PH_Q4: begin
				if (op_q == OP_NONE) begin
					unsup_d = 1'b1;
				end else begin
					unsup_d = 1'b0;
					flags_d = alu_q.flags;
					if (is_file_op(op_q) && instr_q[DEST_BIT]) begin
						mem_we    = 1'b1;
						mem_waddr = instr_q[6:0];
						mem_wdata = alu_q.res;
					end else begin
						accum_d = alu_q.res;
					end
				end
				phase_d = PH_IDLE;
			end
		endcase

		// Write channel: address and data may arrive in either order.
		if (s_awvalid && s_awready) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			w_have_d = 1'b1;
			wdata_d  = s_wdata;
			wstrb_d  = s_wstrb;
		end
		if (wr_go) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			unique case ({awaddr_q[7:2], 2'b00})
				OFS_INSTR: begin
					wr_word = merge_strb({18'h0, instr_q}, wdata_q, wstrb_q);
					instr_d = wr_word[13:0];
					phase_d = PH_Q1;
				end
				OFS_ACCUM: begin
					wr_word = merge_strb({24'h0, accum_q}, wdata_q, wstrb_q);
					accum_d = wr_word[7:0];
				end
				OFS_STATUS: begin
					wr_word    = merge_strb(status_word, wdata_q, wstrb_q);
					flags_d.c  = wr_word[STAT_C_BIT];
					flags_d.dc = wr_word[STAT_DC_BIT];
					flags_d.z  = wr_word[STAT_Z_BIT];
				end
				OFS_FADDR: begin
					wr_word = merge_strb({25'h0, faddr_q}, wdata_q, wstrb_q);
					faddr_d = wr_word[6:0];
				end
				OFS_FDATA: begin
					mem_we    = wstrb_q[0];
					mem_wdata = wdata_q[7:0];
				end
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		if (s_bvalid && s_bready) bvalid_d = 1'b0;

		// Read channel: file data needs one extra cycle for the memory.
		if (s_rvalid && s_rready) rvalid_d = 1'b0;
		if (rd_go) begin
			rresp_d = RESP_OKAY;
			unique case ({s_araddr[7:2], 2'b00})
				OFS_INSTR:  rdata_d = {18'h0, instr_q};
				OFS_ACCUM:  rdata_d = {24'h0, accum_q};
				OFS_STATUS: rdata_d = status_word;
				OFS_FADDR:  rdata_d = {25'h0, faddr_q};
				OFS_FDATA:  rdata_d = 32'h0000_0000;
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
			if ({s_araddr[7:2], 2'b00} == OFS_FDATA) begin
				mem_re    = 1'b1;
				rd_pend_d = 1'b1;
			end else begin
				rvalid_d = 1'b1;
			end
		end
		if (rd_pend_q) begin
			rdata_d  = {24'h0, mem_rdata};
			rvalid_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q   <= PH_IDLE;
			op_q      <= OP_NONE;
			instr_q   <= INSTR_RST;
			accum_q   <= ACCUM_RST;
			oper_q    <= 8'h00;
			alu_q     <= '{res: 8'h00, flags: FLAGS_RST};
			flags_q   <= FLAGS_RST;
			unsup_q   <= 1'b0;
			faddr_q   <= FADDR_RST;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rvalid_q  <= 1'b0;
			rd_pend_q <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else begin
			phase_q   <= phase_d;
			op_q      <= op_d;
			instr_q   <= instr_d;
			accum_q   <= accum_d;
			oper_q    <= oper_d;
			alu_q     <= alu_d;
			flags_q   <= flags_d;
			unsup_q   <= unsup_d;
			faddr_q   <= faddr_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rd_pend_q <= rd_pend_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	assign s_bvalid  = bvalid_q;
	assign s_bresp   = bresp_q;
	assign s_rvalid  = rvalid_q;
	assign s_rdata   = rdata_q;
	assign s_rresp   = rresp_q;
	assign exec_busy = (phase_q != PH_IDLE);
	assign flags     = flags_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_phase_order: assert property ((phase_q == PH_Q1) |=> (phase_q == PH_Q2)
			##1 (phase_q == PH_Q3) ##1 (phase_q == PH_Q4))
		else $error("instruction phases out of order");

	a_cycle_length: assert property ($rose(exec_busy) |-> exec_busy [*4]
			##1 !exec_busy)
		else $error("instruction cycle is not four clocks");

	a_addl_sum: assert property ((phase_q == PH_Q4 && op_q == OP_ADDL) |=>
			accum_q == 8'($past(accum_q) + $past(instr_q[7:0])))
		else $error("literal add gave the wrong accumulator");

	a_andl_flags: assert property ((phase_q == PH_Q4 && op_q == OP_ANDL) |=>
			accum_q == ($past(accum_q) & $past(instr_q[7:0]))
			&& flags_q.c == $past(flags_q.c) && flags_q.dc == $past(flags_q.dc))
		else $error("literal and wrong or touched carry flags");

	a_addf_file: assert property ((phase_q == PH_Q4 && op_q == OP_ADDF && instr_q[DEST_BIT])
			|-> mem_we && mem_waddr == instr_q[6:0]
			&& mem_wdata == 8'(accum_q + oper_q))
		else $error("file add did not write the sum back");

	a_andf_accum: assert property ((phase_q == PH_Q4 && op_q == OP_ANDF && !instr_q[DEST_BIT])
			|=> accum_q == ($past(accum_q) & $past(oper_q)) && $stable(flags_q.c))
		else $error("file and to accumulator wrong");

	a_dest_file_keeps: assert property ((phase_q == PH_Q4 && is_file_op(op_q)
			&& instr_q[DEST_BIT]) |=> $stable(accum_q))
		else $error("file destination changed the accumulator");

	a_zero_flag: assert property ((phase_q == PH_Q4 && op_q != OP_NONE) |=>
			flags_q.z == ($past(alu_q.res) == 8'h00))
		else $error("zero flag does not match result");

	a_carry_flags: assert property ((phase_q == PH_Q3 && (op_q == OP_ADDL || op_q == OP_ADDF))
			|=> ##1 flags_q.c == ((9'($past(accum_q, 2)) + 9'($past(oper_q, 2))) > 9'h0FF)
			&& flags_q.dc == ((5'($past(accum_q[3:0], 2))
			+ 5'($past(oper_q[3:0], 2))) > 5'h0F))
		else $error("carry or digit carry wrong after add");

endmodule : add_and_literal_file_alu

/* File: test/bus_master.sv */
// Register bus master that stands in for the core decoder side of the datapath.
`timescale 1ns/10ps
module bus_master (
	input  wire logic        aclk,      // Core clock.
	output logic      [7:0]  s_awaddr,  // Write address.
	output logic             s_awvalid, // Write address valid.
	input  wire logic        s_awready, // Write address ready.
	output logic      [31:0] s_wdata,   // Write data.
	output logic             s_wvalid,  // Write data valid.
	input  wire logic        s_wready,  // Write data ready.
	input  wire logic [1:0]  s_bresp,   // Write response.
	input  wire logic        s_bvalid,  // Write response valid.
	output logic      [7:0]  s_araddr,  // Read address.
	output logic             s_arvalid, // Read address valid.
	input  wire logic        s_arready, // Read address ready.
	input  wire logic [31:0] s_rdata,   // Read data.
	input  wire logic [1:0]  s_rresp,   // Read response.
	input  wire logic        s_rvalid   // Read data valid.
);
	initial begin
		s_awaddr  = 8'h00;
		s_awvalid = 1'b0;
		s_wdata   = 32'h0000_0000;
		s_wvalid  = 1'b0;
		s_araddr  = 8'h00;
		s_arvalid = 1'b0;
	end

	// Payloads are inverted once taken, so a slave that samples late sees garbage.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_awvalid && s_awready) begin
				s_awvalid <= 1'b0;
				s_awaddr  <= ~a;
			end
			if (s_wvalid && s_wready) begin
				s_wvalid <= 1'b0;
				s_wdata  <= ~d;
			end
			if (s_bvalid) begin
				r = s_bresp;
				return;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_arvalid && s_arready) begin
				s_arvalid <= 1'b0;
				s_araddr  <= ~a;
			end
			if (s_rvalid) begin
				d = s_rdata;
				r = s_rresp;
				return;
			end
		end
	endtask : rd
endmodule : bus_master

/* File: test/tb.sv */
// Self-checking bench for the add/and datapath with a behavioural reference model.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if (32'(got) !== 32'(ex)) begin num_errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, 32'(ex), 32'(got)); end end
module tb import alu_pkg::*;;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [2:0]  s_awprot = 3'h0;
	logic [2:0]  s_arprot = 3'h0;
	logic [3:0]  s_wstrb = 4'hF;
	logic        s_bready = 1'b1;
	logic        s_rready = 1'b1;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
	logic        s_arvalid, s_arready, s_rvalid, exec_busy;
	flags_t      flags;
	int          num_errors = 0;
	int          total_checks = 0;
	int          unsup = 0;
	logic [31:0] seed = 32'h0001_3BF2;
	logic [5:0]  opc_tab [6] = '{6'h3E, 6'h3F, 6'h39, 6'h07, 6'h05, 6'h08};
	// Rows: operation, accumulator, operand, destination, file address, preset flags.
	int          dir [8][6] = '{'{0, 8'h10, 8'h15, 0, 8'h00, 0}, '{2, 8'hA3, 8'h5F, 0, 8'h00, 3},
		'{3, 8'h17, 8'hC2, 0, 8'h7F, 0}, '{4, 8'h17, 8'hC2, 1, 8'h00, 3},
		'{1, 8'h80, 8'h80, 0, 8'h00, 0}, '{0, 8'h0F, 8'h01, 0, 8'h00, 4},
		'{5, 8'h55, 8'h66, 1, 8'h01, 5}, '{3, 8'hFF, 8'h01, 1, 8'h40, 0}};

	add_and_literal_file_alu dut_u (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arprot, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.exec_busy, .flags);
	bus_master m_u (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid);

	always #25 aclk = ~aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// A whole word of shifts per draw keeps successive values uncorrelated.
	task automatic rnd(output logic [31:0] x);
		repeat (32) seed = lfsr(seed);
		x = seed;
	endtask : rnd

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic run(input int op, input int a0, input int v, input int d, input int f,
			input int fl);
		logic [31:0] rd;
		logic [1:0]  r;
		int          res, acc, fv, n, c, dc, z;
		acc = a0;
		fv  = v;
		c   = fl % 2;
		dc  = fl / 2 % 2;
		z   = fl / 4;
		m_u.wr(OFS_ACCUM, 32'(a0), r);
		m_u.wr(OFS_FADDR, 32'(f), r);
		m_u.wr(OFS_FDATA, 32'(v), r);
		m_u.wr(OFS_STATUS, 32'(fl), r);
		m_u.wr(OFS_INSTR, {18'h00000, opc_tab[op], (op > 2) ? 8'(d * 128 + f) : 8'(v)}, r);
		`CHK("bresp", RESP_OKAY, r)
		n = 0;
		while (exec_busy === 1'b1 && n < 8) begin
			n++;
			@(posedge aclk);
		end
		`CHK("busy_len", PHASES_PER_CYCLE, n)
		unsup = (op == 5);
		if (op == 0 || op == 1 || op == 3) begin
			res = a0 + v;
			c   = res / 256;
			dc  = (a0 % 16 + v % 16) / 16;
			res = res % 256;
		end else begin
			res = a0 & v;
		end
		if (op < 5) z = (res == 0);
		if (op < 3 || (op < 5 && d == 0)) acc = res;
		else if (op < 5) fv = res;
		m_u.rd(OFS_ACCUM, rd, r);
		`CHK("accum", acc, rd)
		`CHK("rresp", RESP_OKAY, r)
		m_u.rd(OFS_FDATA, rd, r);
		`CHK("file", fv, rd)
		`CHK("rresp_file", RESP_OKAY, r)
		m_u.rd(OFS_STATUS, rd, r);
		`CHK("status", unsup * 512 + z * 4 + dc * 2 + c, rd)
		`CHK("flags", z * 4 + dc * 2 + c, flags)
	endtask : run

	initial begin
		logic [31:0] x;
		logic [31:0] rd;
		logic [1:0]  r;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		m_u.rd(OFS_ACCUM, rd, r);
		`CHK("accum_rst", 0, rd)
		m_u.rd(OFS_STATUS, rd, r);
		`CHK("status_rst", 0, rd)
		m_u.rd(8'h20, rd, r);
		`CHK("rresp_unmapped", RESP_SLVERR, r)
		`CHK("rdata_unmapped", 0, rd)
		m_u.wr(8'h20, 32'h0000_00FF, r);
		`CHK("bresp_unmapped", RESP_SLVERR, r)
		foreach (dir[i])
			run(dir[i][0], dir[i][1], dir[i][2], dir[i][3], dir[i][4], dir[i][5]);
		repeat (40) begin
			rnd(x);
			run(x[2:0] % 6, x[10:3], x[18:11], x[19], x[26:20], x[29:27]);
		end
		end_sim();
	end

	// The whole sequence needs well under two thousand cycles; this bound only catches a hang.
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		end_sim();
	end
endmodule : tb
